// *** clk_switch_ctrl.sv ***
// Purpose: Clock source select and clock monitor control register with gated writes
// Assumes: Stability and inactivity indications are synchronous to aclk
// Notes: Glitch-free clock muxes sit outside; this block drives their selects
// How it works
// - Select write ignored unless target clock enabled and stable.
// - Internal enable stays set until select has moved to external.
// - Monitor enable sets only with both clocks on and stable.
// - Monitor interrupt enable sets only when monitor enable already set.
// - Flag clears by read showing it set then write zero.
// - Monitor enable stays set when stability is later lost.
// - Detected inactive clock deselected; active one drives both clock outputs.
// - Select bit updated on fallback, showing surviving source.
// - Bits 7..0: irq enable, flag, monitor, select, int on/stable, ext on/stable.
// - Select one picks external, zero internal; internal after reset.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module clk_switch_ctrl #(
   parameter int addr_width = 4
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [addr_width-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [addr_width-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Clock generator status
   input wire logic int_clock_stable,
   input wire logic ext_clock_stable,
   input wire logic int_clock_off,
   input wire logic ext_clock_off,
   // Clock generator control
   output logic int_clock_on,
   output logic ext_clock_on,
   output logic osc_out_select_ext,
   output logic timebase_select_ext,
   output logic monitor_enable,
   // Interrupt
   output logic irq
);
   logic wr_en, rd_en, rd_ok, wr_ok;
   logic [addr_width-1:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0] wr_strb;
   logic [1:0] irq_status, irq_enable, irq_set, irq_clear;
   logic irq_enable_we;

   logic clock_select, monitor_irq_enable, monitor_flag, flag_read_armed;
   logic next_clock_select, next_int_on, next_ext_on, next_mon_en, next_mon_ie;
   logic next_flag, next_armed, next_osc_sel, next_tb_sel;
   logic [7:0] ctrl_view;
   logic ctrl_wr, ctrl_rd, fail_int, fail_ext;
   logic [7:0] wbyte;

   function automatic logic off_match(input logic [3:0] a, input logic [3:0] off);
      off_match = (a[3:2] == off[3:2]);
   endfunction : off_match

   clk_switch_axil #(
      .addr_width(addr_width)
   ) u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok),
      .wr_ok(wr_ok)
   );

   clk_switch_irq #(
      .width(clk_switch_pkg::irq_width)
   ) u_irq (
      .aclk(aclk),
      .aresetn(aresetn),
      .set(irq_set),
      .clear(irq_clear),
      .enable_we(irq_enable_we),
      .enable_wdata(wr_data[1:0]),
      .status(irq_status),
      .enable(irq_enable),
      .irq(irq)
   );

   // Register view; stable bits are live inputs
   always_comb begin
      ctrl_view = {monitor_irq_enable, monitor_flag, monitor_enable, clock_select,
                   int_clock_on, int_clock_stable, ext_clock_on, ext_clock_stable};
   end

   // Read decode
   always_comb begin
      rd_ok = ((rd_addr >> 4) == '0);
      if (off_match(rd_addr[3:0], clk_switch_pkg::ctrl_offset)) begin
         rd_data = {24'h0, ctrl_view};
      end else if (off_match(rd_addr[3:0], clk_switch_pkg::irq_status_offset)) begin
         rd_data = {30'h0, irq_status};
      end else if (off_match(rd_addr[3:0], clk_switch_pkg::irq_clear_offset)) begin
         rd_data = 32'h0;
      end else if (off_match(rd_addr[3:0], clk_switch_pkg::irq_enable_offset)) begin
         rd_data = {30'h0, irq_enable};
      end else begin
         rd_data = 32'h0;
         rd_ok = 1'b0;
      end
   end

   // Write decode; only an upper address bit beyond the map is unmapped
   always_comb begin
      wr_ok = (wr_addr >> 4) == '0;
      ctrl_wr = wr_en && wr_ok && wr_strb[0]
                && off_match(wr_addr[3:0], clk_switch_pkg::ctrl_offset);
      ctrl_rd = rd_en && rd_ok && off_match(rd_addr[3:0], clk_switch_pkg::ctrl_offset);
      irq_enable_we = wr_en && wr_ok && wr_strb[0]
                      && off_match(wr_addr[3:0], clk_switch_pkg::irq_enable_offset);
      irq_clear = (wr_en && wr_ok && wr_strb[0]
                   && off_match(wr_addr[3:0], clk_switch_pkg::irq_clear_offset))
                  ? wr_data[1:0] : 2'h0;
      wbyte = wr_data[7:0];
   end

   // Control register next state
   always_comb begin
      fail_int = monitor_enable && int_clock_off && !ext_clock_off;
      fail_ext = monitor_enable && ext_clock_off && !int_clock_off;
      next_clock_select = clock_select;
      next_int_on = int_clock_on;
      next_ext_on = ext_clock_on;
      next_mon_en = monitor_enable;
      next_mon_ie = monitor_irq_enable;
      next_flag = monitor_flag;
      next_armed = flag_read_armed;
      if (ctrl_wr) begin
         next_ext_on = wbyte[clk_switch_pkg::ext_clock_on_bit];
         if (wbyte[clk_switch_pkg::clock_select_bit] != clock_select) begin
            if (wbyte[clk_switch_pkg::clock_select_bit]
                ? (ext_clock_on && ext_clock_stable)
                : (int_clock_on && int_clock_stable)) begin
               next_clock_select = wbyte[clk_switch_pkg::clock_select_bit];
            end
         end
         if (wbyte[clk_switch_pkg::int_clock_on_bit] || clock_select) begin
            next_int_on = wbyte[clk_switch_pkg::int_clock_on_bit];
         end
         if (!wbyte[clk_switch_pkg::monitor_enable_bit]) begin
            next_mon_en = 1'b0;
         end else if (int_clock_on && ext_clock_on && int_clock_stable && ext_clock_stable) begin
            next_mon_en = 1'b1;
         end
         if (!wbyte[clk_switch_pkg::monitor_irq_enable_bit]) begin
            next_mon_ie = 1'b0;
         end else if (monitor_enable) begin
            next_mon_ie = 1'b1;
         end
         if (flag_read_armed && !wbyte[clk_switch_pkg::monitor_flag_bit]) begin
            next_flag = 1'b0;
         end
         next_armed = 1'b0;
      end
      if (ctrl_rd && monitor_flag) begin
         next_armed = 1'b1;
      end
      if (fail_int || fail_ext) begin
         next_flag = 1'b1;
         next_clock_select = fail_int;
      end
      next_osc_sel = next_clock_select;
      // Timebase follows the external enable unless a failure forces a side
      next_tb_sel = fail_int ? 1'b1 : (fail_ext ? 1'b0 : next_ext_on);
      irq_set = {fail_int || fail_ext, next_flag && !monitor_flag && monitor_irq_enable};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clock_select <= clk_switch_pkg::ctrl_reset[clk_switch_pkg::clock_select_bit];
         int_clock_on <= clk_switch_pkg::ctrl_reset[clk_switch_pkg::int_clock_on_bit];
         ext_clock_on <= clk_switch_pkg::ctrl_reset[clk_switch_pkg::ext_clock_on_bit];
         monitor_enable <= clk_switch_pkg::ctrl_reset[clk_switch_pkg::monitor_enable_bit];
         monitor_irq_enable <= clk_switch_pkg::ctrl_reset[clk_switch_pkg::monitor_irq_enable_bit];
         monitor_flag <= clk_switch_pkg::ctrl_reset[clk_switch_pkg::monitor_flag_bit];
         flag_read_armed <= 1'b0;
         osc_out_select_ext <= 1'b0;
         timebase_select_ext <= 1'b0;
      end else begin
         clock_select <= next_clock_select;
         int_clock_on <= next_int_on;
         ext_clock_on <= next_ext_on;
         monitor_enable <= next_mon_en;
         monitor_irq_enable <= next_mon_ie;
         monitor_flag <= next_flag;
         flag_read_armed <= next_armed;
         osc_out_select_ext <= next_osc_sel;
         timebase_select_ext <= next_tb_sel;
      end
   end

   // Assertions
   property p_sel_gate;
      @(posedge aclk) disable iff (!aresetn)
      (ctrl_wr && wbyte[4] && !clock_select && !(ext_clock_on && ext_clock_stable)
       && !fail_int) |=> !clock_select;
   endproperty
   a_sel_gate: assert property (p_sel_gate) else $error("select moved without ready target");

   property p_int_hold;
      @(posedge aclk) disable iff (!aresetn)
      (!clock_select && int_clock_on) |=> int_clock_on;
   endproperty
   a_int_hold: assert property (p_int_hold) else $error("internal clock dropped while selected");

   property p_mon_gate;
      @(posedge aclk) disable iff (!aresetn)
      $rose(monitor_enable) |-> $past(int_clock_on && ext_clock_on
                                      && int_clock_stable && ext_clock_stable);
   endproperty
   a_mon_gate: assert property (p_mon_gate) else $error("monitor enabled without prerequisites");

   property p_ie_gate;
      @(posedge aclk) disable iff (!aresetn)
      $rose(monitor_irq_enable) |-> $past(monitor_enable);
   endproperty
   a_ie_gate: assert property (p_ie_gate) else $error("irq enable set without monitor");

   property p_flag_clear;
      @(posedge aclk) disable iff (!aresetn)
      $fell(monitor_flag) |-> $past(ctrl_wr && flag_read_armed && !wbyte[6]);
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag cleared without read then write");

   property p_mon_stay;
      @(posedge aclk) disable iff (!aresetn)
      (monitor_enable && !(ctrl_wr && !wbyte[5])) |=> monitor_enable;
   endproperty
   a_mon_stay: assert property (p_mon_stay) else $error("monitor enable dropped by itself");

   property p_fallback;
      @(posedge aclk) disable iff (!aresetn)
      fail_ext |=> (!osc_out_select_ext && !timebase_select_ext && !clock_select);
   endproperty
   a_fallback: assert property (p_fallback) else $error("external failure not deselected");

   property p_fallback_sel;
      @(posedge aclk) disable iff (!aresetn)
      fail_int |=> (clock_select && osc_out_select_ext && monitor_flag);
   endproperty
   a_fallback_sel: assert property (p_fallback_sel) else $error("select not updated on fallback");

   property p_osc_follow;
      @(posedge aclk) disable iff (!aresetn)
      1'b1 |-> (osc_out_select_ext == clock_select);
   endproperty
   a_osc_follow: assert property (p_osc_follow) else $error("osc select differs from select bit");

   c_switch_ext: cover property (@(posedge aclk) disable iff (!aresetn) $rose(clock_select));
   c_mon_on: cover property (@(posedge aclk) disable iff (!aresetn) $rose(monitor_irq_enable));
   c_fallback: cover property (@(posedge aclk) disable iff (!aresetn) fail_ext);
   c_flag_clr: cover property (@(posedge aclk) disable iff (!aresetn) $fell(monitor_flag));
endmodule : clk_switch_ctrl
`default_nettype wire

// *** clk_switch_pkg.sv ***
// Purpose: Shared constants for the clock source switch and monitor control block
// Assumes: AXI4-Lite register access with 32-bit data
// Notes: One 8-bit control register plus interrupt status, clear and enable words
package clk_switch_pkg;
   // Register byte offsets
   localparam logic [3:0] ctrl_offset = 4'h0;
   localparam logic [3:0] irq_status_offset = 4'h4;
   localparam logic [3:0] irq_clear_offset = 4'h8;
   localparam logic [3:0] irq_enable_offset = 4'hC;
   // Control register bit positions
   localparam int monitor_irq_enable_bit = 7;
   localparam int monitor_flag_bit = 6;
   localparam int monitor_enable_bit = 5;
   localparam int clock_select_bit = 4;
   localparam int int_clock_on_bit = 3;
   localparam int int_clock_stable_bit = 2;
   localparam int ext_clock_on_bit = 1;
   localparam int ext_clock_stable_bit = 0;
   // Interrupt status bit positions
   localparam int irq_monitor_bit = 0;
   localparam int irq_fallback_bit = 1;
   localparam int irq_width = 2;
   // Reset values: internal clock on and selected
   localparam logic [7:0] ctrl_reset = 8'h08;
   localparam logic [1:0] irq_reset = 2'h0;
   // AXI responses
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;
   typedef enum logic [1:0] {
      sel_int = 2'b00,
      sel_ext = 2'b01
   } source_t;
endpackage : clk_switch_pkg

// *** clk_switch_irq.sv ***
// Purpose: Sticky interrupt status with clear and enable registers
// Assumes: Set pulses come from the control logic in the same clock domain
// Notes: A set in the cycle of a clear wins
`timescale 1ns/1ps
`default_nettype none
module clk_switch_irq #(
   parameter int width = 2
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Events and software access
   input wire logic [width-1:0] set,
   input wire logic [width-1:0] clear,
   input wire logic enable_we,
   input wire logic [width-1:0] enable_wdata,
   // State
   output logic [width-1:0] status,
   output logic [width-1:0] enable,
   output logic irq
);
   logic [width-1:0] next_status;
   logic [width-1:0] next_enable;
   logic next_irq;

   initial begin
      if (width < 1) $error("width must be at least 1");
   end

   always_comb begin
      next_status = (status & ~clear) | set;
      next_enable = enable_we ? enable_wdata : enable;
      next_irq = |(next_status & next_enable);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= '0;
         enable <= '0;
         irq <= 1'b0;
      end else begin
         status <= next_status;
         enable <= next_enable;
         irq <= next_irq;
      end
   end
endmodule : clk_switch_irq
`default_nettype wire

// *** clk_switch_axil.sv ***
// Purpose: AXI4-Lite slave front end producing one-cycle register strobes
// Assumes: One write and one read under way at a time
// Notes: Write address and data taken in either order; response two cycles after both
`timescale 1ns/1ps
`default_nettype none
module clk_switch_axil #(
   parameter int addr_width = 4
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [addr_width-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [addr_width-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Register side
   output logic wr_en,
   output logic [addr_width-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   output logic rd_en,
   output logic [addr_width-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok,
   input wire logic wr_ok
);
   logic have_aw, have_w, next_have_aw, next_have_w;
   logic next_bvalid, next_rvalid, next_wr_en, next_rd_en;
   logic [addr_width-1:0] next_wr_addr, next_rd_addr;
   logic [31:0] next_wr_data, next_rdata;
   logic [3:0] next_wr_strb;
   logic [1:0] next_bresp, next_rresp;
   logic rd_pend, next_rd_pend;
   logic next_awready, next_wready, next_arready;

   initial begin
      if (addr_width < 4) $error("addr_width must be at least 4");
   end

   always_comb begin
      next_have_aw = have_aw | (awvalid & awready);
      next_have_w = have_w | (wvalid & wready);
      next_wr_addr = (awvalid && awready) ? awaddr : wr_addr;
      next_wr_data = (wvalid && wready) ? wdata : wr_data;
      next_wr_strb = (wvalid && wready) ? wstrb : wr_strb;
      next_wr_en = 1'b0;
      next_bvalid = bvalid && !bready;
      next_bresp = bresp;
      if (have_aw && have_w && !wr_en && !bvalid) begin
         next_wr_en = 1'b1;
         next_have_aw = 1'b0;
         next_have_w = 1'b0;
      end
      if (wr_en) begin
         next_bvalid = 1'b1;
         next_bresp = wr_ok ? clk_switch_pkg::resp_okay : clk_switch_pkg::resp_slverr;
      end
      // Read: address taken, strobe register stage, then data
      next_rd_en = arvalid && arready;
      next_rd_addr = (arvalid && arready) ? araddr : rd_addr;
      next_rd_pend = rd_pend;
      next_rvalid = rvalid && !rready;
      next_rdata = rdata;
      next_rresp = rresp;
      if (rd_en) begin
         next_rvalid = 1'b1;
         next_rdata = rd_data;
         next_rresp = rd_ok ? clk_switch_pkg::resp_okay : clk_switch_pkg::resp_slverr;
      end
      // Readies registered from next-cycle pending state, so they leave a flop
      next_awready = !next_have_aw && !next_bvalid && !next_wr_en;
      next_wready = !next_have_w && !next_bvalid && !next_wr_en;
      next_arready = !next_rd_pend && !next_rvalid && !next_rd_en;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         have_aw <= 1'b0;
         have_w <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         arready <= 1'b1;
         wr_en <= 1'b0;
         wr_addr <= '0;
         wr_data <= 32'h0;
         wr_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= 2'h0;
         rd_en <= 1'b0;
         rd_addr <= '0;
         rd_pend <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= 2'h0;
      end else begin
         have_aw <= next_have_aw;
         have_w <= next_have_w;
         awready <= next_awready;
         wready <= next_wready;
         arready <= next_arready;
         wr_en <= next_wr_en;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
         wr_strb <= next_wr_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rd_en <= next_rd_en;
         rd_addr <= next_rd_addr;
         rd_pend <= next_rd_pend;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end
endmodule : clk_switch_axil
`default_nettype wire

// *** clock_source_switch_monitor_ctrl_tb.sv ***
// Purpose: Self-checking bench for the clock source switch and monitor control block
// Assumes: Stable and inactivity inputs are driven straight from the bench, synchronous to aclk
// Notes: A 4-bit address space has no unmapped word, so the write-only clear word is read instead
`timescale 1ns/1ps
`default_nettype none
module clock_source_switch_monitor_ctrl_tb;
   localparam logic [3:0] ctrl_a = clk_switch_pkg::ctrl_offset;
   localparam logic [3:0] stat_a = clk_switch_pkg::irq_status_offset;
   localparam logic [3:0] clr_a = clk_switch_pkg::irq_clear_offset;
   localparam logic [3:0] ien_a = clk_switch_pkg::irq_enable_offset;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, r;
   logic [1:0] bresp, rresp;
   logic int_clock_stable, ext_clock_stable, int_clock_off, ext_clock_off;
   logic int_clock_on, ext_clock_on, osc_out_select_ext, timebase_select_ext;
   logic monitor_enable, irq;
   logic [31:0] seed = 32'h552173D6;
   int n_errors = 0;
   int comparisons = 0;
   int i;

   clk_switch_ctrl dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .int_clock_stable(int_clock_stable), .ext_clock_stable(ext_clock_stable),
      .int_clock_off(int_clock_off), .ext_clock_off(ext_clock_off),
      .int_clock_on(int_clock_on), .ext_clock_on(ext_clock_on),
      .osc_out_select_ext(osc_out_select_ext), .timebase_select_ext(timebase_select_ext),
      .monitor_enable(monitor_enable), .irq(irq));

   always #5 aclk = ~aclk;

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // Control word after a fallback: both clocks on and stable, flag and monitor set
   function automatic logic [31:0] exp_ctrl(input logic cie, input logic ext_dead);
      return {24'h0, cie, 2'h3, ~ext_dead, 4'hF};
   endfunction : exp_ctrl

   task automatic tally_and_finish();
      if (n_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic give_up();
      n_errors++;
      tally_and_finish();
   endtask : give_up

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   // Handshakes judged at the falling edge, where the pre-edge values are settled
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
      logic aw_hs, w_hs, b_hs;
      logic [1:0] resp;
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      b_hs = 1'h0;
      resp = 2'h3;
      for (n = 0; n < 40 && !b_hs; n++) begin
         @(negedge aclk);
         aw_hs = awvalid && awready;
         w_hs = wvalid && wready;
         b_hs = bvalid && bready;
         resp = bresp;
         @(posedge aclk);
         if (aw_hs) awvalid <= 1'h0;
         if (w_hs) wvalid <= 1'h0;
      end
      bready <= 1'h0;
      if (!b_hs) give_up();
      @(negedge aclk);
      check({30'h0, resp}, {30'h0, clk_switch_pkg::resp_okay});
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      logic ar_hs, r_hs;
      logic [31:0] d;
      logic [1:0] resp;
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      r_hs = 1'h0;
      d = 32'h0;
      resp = 2'h3;
      for (n = 0; n < 40 && !r_hs; n++) begin
         @(negedge aclk);
         ar_hs = arvalid && arready;
         r_hs = rvalid && rready;
         d = rdata;
         resp = rresp;
         @(posedge aclk);
         if (ar_hs) arvalid <= 1'h0;
      end
      rready <= 1'h0;
      if (!r_hs) give_up();
      @(negedge aclk);
      check(d, exp);
      check({30'h0, resp}, {30'h0, clk_switch_pkg::resp_okay});
   endtask : rd

   // Kill one clock while the monitor runs, then release the inactivity input
   // Slow external option taken as matched, so inactivity inputs are trusted
   task automatic fallback(input logic ext_dead, input logic [31:0] status_exp);
      int n;
      @(posedge aclk);
      ext_clock_off <= ext_dead;
      int_clock_off <= ~ext_dead;
      for (n = 0; n < 20 && osc_out_select_ext !== !ext_dead; n++) @(negedge aclk);
      if (n == 20) give_up();
      check(osc_out_select_ext, !ext_dead);
      check(timebase_select_ext, !ext_dead);
      @(posedge aclk);
      ext_clock_off <= 1'h0;
      int_clock_off <= 1'h0;
      rd(stat_a, status_exp);
      check(irq, 1'h1);
   endtask : fallback

   initial begin
      aclk = 1'h0;
      aresetn = 1'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wstrb, wdata} = 44'h0;
      {int_clock_stable, ext_clock_stable, int_clock_off, ext_clock_off} = 4'h0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      @(negedge aclk);
      check(int_clock_on, 1'h1);
      check(osc_out_select_ext, 1'h0);
      rd(ctrl_a, 32'h08);
      wr(ctrl_a, 32'h1B);
      rd(ctrl_a, 32'h0A);
      check(osc_out_select_ext, 1'h0);
      wr(ctrl_a, 32'h02);
      rd(ctrl_a, 32'h0A);
      @(posedge aclk);
      ext_clock_stable <= 1'h1;
      wr(ctrl_a, 32'h1B);
      rd(ctrl_a, 32'h1B);
      check(osc_out_select_ext, 1'h1);
      check(ext_clock_on, 1'h1);
      wr(ctrl_a, 32'h13);
      rd(ctrl_a, 32'h13);
      check(int_clock_on, 1'h0);
      wr(ctrl_a, 32'h3B);
      rd(ctrl_a, 32'h1B);
      check(monitor_enable, 1'h0);
      @(posedge aclk);
      int_clock_stable <= 1'h1;
      wr(ctrl_a, 32'hBF);
      rd(ctrl_a, 32'h3F);
      wr(ctrl_a, 32'hBF);
      rd(ctrl_a, 32'hBF);
      @(posedge aclk);
      int_clock_stable <= 1'h0;
      rd(ctrl_a, 32'hBB);
      check(monitor_enable, 1'h1);
      @(posedge aclk);
      int_clock_stable <= 1'h1;
      wr(ien_a, 32'h3);
      fallback(1'h1, 32'h3);
      // No read has shown the flag yet, so this zero must not clear it
      wr(ctrl_a, 32'hAF);
      rd(ctrl_a, exp_ctrl(1'h1, 1'h1));
      wr(ctrl_a, 32'hEF);
      rd(ctrl_a, exp_ctrl(1'h1, 1'h1));
      wr(ctrl_a, 32'hAF);
      rd(ctrl_a, 32'hAF);
      wr(ien_a, 32'h0);
      check(irq, 1'h0);
      rd(stat_a, 32'h3);
      wr(clr_a, 32'h3);
      rd(stat_a, 32'h0);
      rd(clr_a, 32'h0);
      wr(ien_a, 32'h3);
      wr(ctrl_a, 32'h0F);
      check(monitor_enable, 1'h0);
      wr(ctrl_a, 32'h2F);
      fallback(1'h0, 32'h2);
      rd(ctrl_a, exp_ctrl(1'h0, 1'h0));
      // Byte 0 unstrobed leaves control alone; enable word follows random data
      for (i = 0; i < 8; i++) begin
         r = xs();
         wr(ctrl_a, r, {r[3:1], 1'h0});
         rd(ctrl_a, exp_ctrl(1'h0, 1'h0));
         wr(ien_a, r);
         rd(ien_a, {30'h0, r[1:0]});
         check(irq, r[1]);
      end
      tally_and_finish();
   end
endmodule : clock_source_switch_monitor_ctrl_tb
`default_nettype wire
